// [adcf_pkg.sv]
// Purpose: Shared constants and types.
// Assumes: 40 MHz clock; converter clock divided from it.
// Notes:   Offsets are AXI4-Lite byte addresses.
package adcf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_CFG     = 8'h04;
  localparam logic [7:0] REG_PERIOD  = 8'h08;
  localparam logic [7:0] REG_STATUS  = 8'h0c;
  localparam logic [7:0] REG_SAMPLE  = 8'h20;

  // Control field positions
  localparam int CTRL_TMR_EN   = 0;
  localparam int CTRL_AUTO     = 1;
  localparam int CTRL_RECOV    = 2;
  localparam int CTRL_WC_LSB   = 4;
  localparam int CTRL_INIT     = 8;
  localparam int CTRL_KICK     = 9;

  // Status field positions
  localparam int STAT_BUSY     = 0;
  localparam int STAT_IRQ      = 1;
  localparam int STAT_FAULT    = 2;
  localparam int STAT_READY    = 3;
  localparam int STAT_CNT_LSB  = 8;
  localparam int STAT_LAST_LSB = 16;

  // Out-of-range bit in device status
  localparam int FAULT_BIT     = 5;

  // Reset values
  localparam logic [3:0]  WC_RST      = 4'h8;
  localparam logic [11:0] CFG_RST     = 12'h000;
  localparam logic [15:0] PERIOD_RST  = 16'h0190;

  // Device address selects
  localparam logic ADDR_FIFO   = 1'b0;
  localparam logic ADDR_STATCTL = 1'b1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int CLK_MHZ       = CLK_HZ / 1_000_000;
  localparam int CCLK_HALF     = 2;               // Converter clock half period
  localparam int CCLK_CYC      = 2 * CCLK_HALF;
  localparam int PULSE_CCLK    = 2;               // Start pulse, converter clocks
  localparam int CONV_MAX_CCLK = 57;              // Longest conversion, converter clocks
  localparam int ACQ_NS        = 2000;            // Acquisition, ns
  localparam int MAX_RATE_KHZ  = 100;             // Throughput ceiling, kHz
  localparam int PULSE_CYC     = PULSE_CCLK * CCLK_CYC;
  localparam int CONV_CYC      = CONV_MAX_CCLK * CCLK_CYC;
  localparam int ACQ_CYC       = (ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int RATE_CYC      = (CLK_HZ / 1000 + MAX_RATE_KHZ - 1) / MAX_RATE_KHZ;
  localparam int SCHED_CYC     = PULSE_CYC + CONV_CYC + ACQ_CYC;
  localparam int MIN_PERIOD_CYC = (RATE_CYC > SCHED_CYC) ? RATE_CYC : SCHED_CYC;
  localparam int STROBE_CYC    = 6;               // Covers the three-stage data sampler
  localparam int GAP_CYC       = 2;
  localparam int OP_CYC        = STROBE_CYC + GAP_CYC + 2;

  ////////////////////////////////////////////////////////////////////////////
  // Bus job kinds
  typedef enum logic [1:0] {
    JOB_INIT,
    JOB_STAT,
    JOB_FIFO
  } adcf_job_e;

endpackage

// [adcf_sync.sv]
// Purpose: Three-stage sampler for asynchronous inputs.
// Assumes: Synchronous active-high reset.
// Notes:   Output follows once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module adcf_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         sys_rst,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  // Stage one feeds stage two only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Agreement filter rejects a one-cycle glitch
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= RST_VAL;
    end else begin
      q <= (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & q);
    end
  end

endmodule
`default_nettype wire

// [adcf_host.sv]
// Purpose: Host controller for a sampling converter with a FIFO.
// Assumes: AXI4-Lite register port; device pins asynchronous.
// Notes:   Start timer, init write, service and bus cycles.
//
// How it works
// RULE1: Own timer generates conversion starts independently.
// RULE2: Device asserts level interrupt at word count.
// RULE3: On interrupt, read FIFO words from device.
// RULE4: Hold bus cycle while device busy is low.
// RULE5: Separate read and write strobes driven directly.
// RULE6: Write status/control word after reset.
// RULE7: Read status bit five before samples.
// RULE8: Device flags each word under or over range.
// RULE9: On fault, drop samples and rewrite control.
// RULE10: Start period never below 100 kHz rate.
// RULE11: Start pulse lasts two converter clocks.
// RULE12: Conversion lasts at most 57 converter clocks.
// RULE13: Two microseconds acquisition before next start.
// RULE14: Bus cycles only outside conversion window.
// RULE15: Converter clock divided from system clock.
// RULE16: Device holds input at start rising edge.
// RULE17: Conversion takes 56 or 57 clocks.
// RULE18: Samples are 12-bit two's complement.
// RULE19: Device returns oldest sample first.
// RULE20: Device resets empty with interrupt off.
`timescale 1ns/1ps
`default_nettype none
module adcf_host
  import adcf_pkg::*;
#(
  parameter int DATA_W = 12,
  parameter int DEPTH  = 8
) (
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              sys_rst,
  // AXI4-Lite write channels
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Converter timing pins
  output logic                   adc_clk,
  output logic                   convert_start_n,
  // Converter bus pins
  output logic                   cs_n,
  output logic                   read_strobe_n,
  output logic                   write_strobe_n,
  output logic                   addr0,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe_n,
  // Converter status pins
  input  wire logic              busy_n,
  input  wire logic              fifo_level_irq_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_STROBE,
    ST_GAP
  } adcf_state_e;

  adcf_state_e       state_ff;
  adcf_job_e         job_ff;
  logic              tmr_en_ff;
  logic              auto_ff;
  logic              recov_ff;
  logic [3:0]        wc_ff;
  logic [11:0]       cfg_ff;
  logic [15:0]       period_ff;
  logic              init_pend_ff;
  logic              kick_pend_ff;
  logic              fault_ff;
  logic              ready_ff;
  logic [11:0]       last_stat_ff;
  logic [3:0]        stored_ff;
  logic [3:0]        left_ff;
  logic [3:0]        cnt_ff;
  logic [15:0]       tmr_cnt_ff;
  logic [1:0]        div_ff;
  logic [DATA_W-1:0] sample_ff [DEPTH];
  logic [DATA_W-1:0] data_s;
  logic              busy_n_s;
  logic              irq_n_s;
  logic [15:0]       eff_period;
  logic              bus_window;
  logic [31:0]       wr_word;
  logic [31:0]       rd_word;
  logic              rd_bad;
  logic              wr_bad;
  logic              wr_fire;
  logic              rd_fire;
  logic              fault_set;
  logic              ready_set;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input samplers
  adcf_sync #(.W(DATA_W), .RST_VAL('0)) u_sync_data (
    .clock   (clock),
    .sys_rst (sys_rst),
    .d       (data_in),
    .q       (data_s)
  );

  adcf_sync #(.W(2), .RST_VAL(2'h3)) u_sync_ctl (
    .clock   (clock),
    .sys_rst (sys_rst),
    .d       ({busy_n, fifo_level_irq_n}),
    .q       ({busy_n_s, irq_n_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge for register writes
  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] host_cycle_strobe);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (host_cycle_strobe[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI write: take address and data together
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= wr_fire;
      s_axi_wready  <= wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Unmapped writes report an error
  always_comb begin
    case (s_axi_awaddr)
      REG_CTRL:   wr_word = wmerge({22'h0, 1'b0, 1'b0, wc_ff, 1'b0, recov_ff, auto_ff, tmr_en_ff},
                                   s_axi_wdata, s_axi_wstrb);
      REG_CFG:    wr_word = wmerge({20'h0, cfg_ff}, s_axi_wdata, s_axi_wstrb);
      REG_PERIOD: wr_word = wmerge({16'h0, period_ff}, s_axi_wdata, s_axi_wstrb);
      REG_STATUS: wr_word = wmerge(32'h0, s_axi_wdata, s_axi_wstrb);
      default:    wr_word = 32'h0;
    endcase
    wr_bad = !(s_axi_awaddr == REG_CTRL || s_axi_awaddr == REG_CFG ||
               s_axi_awaddr == REG_PERIOD || s_axi_awaddr == REG_STATUS);
  end

  // Control, configuration and period registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tmr_en_ff <= 1'b0;
      auto_ff   <= 1'b0;
      recov_ff  <= 1'b0;
      wc_ff     <= WC_RST;
      cfg_ff    <= CFG_RST;
      period_ff <= PERIOD_RST;
    end else if (wr_fire) begin
      if (s_axi_awaddr == REG_CTRL) begin
        tmr_en_ff <= wr_word[CTRL_TMR_EN];
        auto_ff   <= wr_word[CTRL_AUTO];
        recov_ff  <= wr_word[CTRL_RECOV];
        wc_ff     <= wr_word[CTRL_WC_LSB +: 4];
      end
      if (s_axi_awaddr == REG_CFG) begin
        cfg_ff <= wr_word[11:0];
      end
      if (s_axi_awaddr == REG_PERIOD) begin
        period_ff <= wr_word[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read channel
  assign rd_fire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;

  always_comb begin
    rd_word = 32'h0;
    rd_bad  = 1'b0;
    if (s_axi_araddr >= REG_SAMPLE && s_axi_araddr < REG_SAMPLE + 8'(4 * DEPTH)) begin
      rd_word = 32'(signed'(sample_ff[s_axi_araddr[4:2]])); // RULE18
    end else begin
      case (s_axi_araddr)
        REG_CTRL:   rd_word = {22'h0, 1'b0, 1'b0, wc_ff, 1'b0, recov_ff, auto_ff, tmr_en_ff};
        REG_CFG:    rd_word = {20'h0, cfg_ff};
        REG_PERIOD: rd_word = {16'h0, period_ff};
        REG_STATUS: rd_word = {4'h0, last_stat_ff, 4'h0, stored_ff, 4'h0, ready_ff, fault_ff,
                               !irq_n_s, state_ff != ST_IDLE};
        default:    rd_bad  = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_bad ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock, locked to the system clock
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      div_ff  <= 2'h0;
      adc_clk <= 1'b0;
    end else if (div_ff == 2'(CCLK_HALF - 1)) begin
      div_ff  <= 2'h0;
      adc_clk <= !adc_clk; // RULE15
    end else begin
      div_ff <= div_ff + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start timer; short periods raised to the minimum
  assign eff_period = (period_ff < 16'(MIN_PERIOD_CYC)) ? 16'(MIN_PERIOD_CYC) : period_ff; // RULE10 RULE13

  always_ff @(posedge clock) begin
    if (sys_rst || !tmr_en_ff) begin
      tmr_cnt_ff      <= 16'h0;
      convert_start_n <= 1'b1;
    end else begin
      tmr_cnt_ff      <= (tmr_cnt_ff == eff_period - 16'h1) ? 16'h0 : tmr_cnt_ff + 16'h1; // RULE1
      convert_start_n <= !(tmr_cnt_ff < 16'(PULSE_CYC)); // RULE11
    end
  end

  // Bus cycles are kept to the acquisition gap so conversions are not stretched
  assign bus_window = !tmr_en_ff ||
                      (tmr_cnt_ff >= 16'(PULSE_CYC + CONV_CYC + 1) && // RULE12 RULE14
                       tmr_cnt_ff <  eff_period - 16'(OP_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // Device bus sequencer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff       <= ST_IDLE;
      job_ff         <= JOB_INIT;
      cs_n           <= 1'b1;
      read_strobe_n  <= 1'b1;
      write_strobe_n <= 1'b1;
      addr0          <= ADDR_FIFO;
      data_out       <= '0;
      data_oe_n      <= 1'b1;
      cnt_ff         <= 4'h0;
      left_ff        <= 4'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (init_pend_ff) begin
            job_ff   <= JOB_INIT; // RULE6
            addr0    <= ADDR_STATCTL;
            state_ff <= ST_WAIT;
          end else if ((auto_ff && !irq_n_s) || kick_pend_ff) begin
            job_ff   <= JOB_STAT; // RULE7
            addr0    <= ADDR_STATCTL;
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Busy low: track-to-hold in progress, hold off
          if (busy_n_s && bus_window) begin // RULE4 RULE14
            cs_n <= 1'b0;
            if (job_ff == JOB_INIT) begin
              write_strobe_n <= 1'b0; // RULE5
              data_out       <= DATA_W'(cfg_ff);
              data_oe_n      <= 1'b0;
            end else begin
              read_strobe_n <= 1'b0; // RULE5
            end
            cnt_ff   <= 4'(STROBE_CYC - 1);
            state_ff <= ST_STROBE;
          end
        end
        ST_STROBE: begin
          if (cnt_ff == 4'h0) begin
            cs_n           <= 1'b1;
            read_strobe_n  <= 1'b1;
            write_strobe_n <= 1'b1;
            data_oe_n      <= 1'b1;
            cnt_ff         <= 4'(GAP_CYC - 1);
            state_ff       <= ST_GAP;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_GAP: begin
          if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else if (job_ff == JOB_INIT) begin
            state_ff <= ST_IDLE;
          end else if (job_ff == JOB_STAT && data_s[FAULT_BIT] && recov_ff) begin
            job_ff   <= JOB_INIT; // RULE9
            state_ff <= ST_WAIT;
          end else if (job_ff == JOB_STAT) begin
            job_ff   <= JOB_FIFO; // RULE3
            addr0    <= ADDR_FIFO;
            left_ff  <= (wc_ff == 4'h0 || wc_ff > 4'(DEPTH)) ? 4'(DEPTH) : wc_ff;
            state_ff <= ST_WAIT;
          end else if (left_ff > 4'h1) begin
            left_ff  <= left_ff - 4'h1;
            state_ff <= ST_WAIT;
          end else begin
            left_ff  <= 4'h0;
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending init and service kick
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      init_pend_ff <= 1'b1; // RULE6
      kick_pend_ff <= 1'b0;
    end else begin
      if (wr_fire && s_axi_awaddr == REG_CTRL && wr_word[CTRL_INIT]) begin
        init_pend_ff <= 1'b1;
      end else if (state_ff == ST_IDLE) begin
        init_pend_ff <= 1'b0;
      end
      if (wr_fire && s_axi_awaddr == REG_CTRL && wr_word[CTRL_KICK]) begin
        kick_pend_ff <= 1'b1;
      end else if (state_ff == ST_IDLE && !init_pend_ff) begin
        kick_pend_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word and samples, in arrival order
  assign fault_set = (state_ff == ST_GAP) && (cnt_ff == 4'h0) && (job_ff == JOB_STAT) &&
                     data_s[FAULT_BIT];
  assign ready_set = (state_ff == ST_GAP) && (cnt_ff == 4'h0) && (job_ff == JOB_FIFO) &&
                     (left_ff <= 4'h1);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      last_stat_ff <= 12'h000;
      stored_ff    <= 4'h0;
    end else if (state_ff == ST_GAP && cnt_ff == 4'h0 && job_ff == JOB_STAT) begin
      last_stat_ff <= 12'(data_s);
      stored_ff    <= 4'h0;
    end else if (state_ff == ST_GAP && cnt_ff == 4'h0 && job_ff == JOB_FIFO &&
                 stored_ff < 4'(DEPTH)) begin
      stored_ff <= stored_ff + 4'h1;
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_sample
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        sample_ff[i] <= '0;
      end else if (state_ff == ST_GAP && cnt_ff == 4'h0 && job_ff == JOB_FIFO &&
                   stored_ff == 4'(i)) begin
        sample_ff[i] <= data_s; // RULE19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags, write one to clear; a new event wins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fault_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else begin
      if (fault_set) begin
        fault_ff <= 1'b1; // RULE7
      end else if (wr_fire && s_axi_awaddr == REG_STATUS && wr_word[STAT_FAULT]) begin
        fault_ff <= 1'b0;
      end
      if (ready_set) begin
        ready_ff <= 1'b1;
      end else if (wr_fire && s_axi_awaddr == REG_STATUS && wr_word[STAT_READY]) begin
        ready_ff <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// [adcf_host_props.sv]
// Purpose: Port checks for the host controller.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound into adcf_host.
`timescale 1ns/1ps
`default_nettype none
module adcf_host_props (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter pins
  input wire logic adc_clk,
  input wire logic convert_start_n,
  input wire logic cs_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  //////////////////////////////////////////////////////////////////////////////
  logic [15:0] gap_ff;
  // Cycles since last start; preset high after reset
  always_ff @(posedge clock) begin
    if (sys_rst) gap_ff <= 16'h0fff;
    else if ($fell(convert_start_n)) gap_ff <= 16'h0000;
    else if (gap_ff != 16'hffff) gap_ff <= gap_ff + 16'h0001;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Handshakes answer next cycle; write response then holds
  a_wr_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
    |=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("write not answered");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
  a_rd_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid) else $error("read not answered");
  // Device timing
  a_start_width: assert property ($fell(convert_start_n)
    |-> !convert_start_n [*8] ##1 convert_start_n) else $error("start pulse width");
  a_start_rate: assert property ($fell(convert_start_n) |-> gap_ff >= 16'h018f) else $error("start too soon");
  a_clk_div: assert property ($rose(adc_clk) |=> adc_clk ##1 !adc_clk ##1 !adc_clk ##1 adc_clk)
    else $error("clock divide");
  // Bus cycles
  a_strobe_sel: assert property (!read_strobe_n || !write_strobe_n
    |-> !cs_n && (read_strobe_n || write_strobe_n)) else $error("strobe without select");
  a_read_len: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*6] ##1 read_strobe_n)
    else $error("read strobe length");
  a_quiet_start: assert property ($fell(cs_n) |-> convert_start_n) else $error("bus during start");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_start: cover property ($fell(convert_start_n));
  c_read: cover property ($fell(read_strobe_n));
  c_ctl: cover property ($fell(write_strobe_n));
endmodule
bind adcf_host adcf_host_props i_props (.*);
`default_nettype wire

// [adcf_dev_model.sv]
// Purpose: Behavioural converter with result queue.
// Assumes: System clock; control b3 irq on, [2:0] count-1.
// Notes:   force_oor forces over range.
`timescale 1ns/1ps
`default_nettype none
module adcf_dev_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Timing and bus pins
  input  wire logic        adc_clk,
  input  wire logic        convert_start_n,
  input  wire logic        cs_n,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic        addr0,
  input  wire logic [11:0] data_out,
  input  wire logic        data_oe_n,
  output logic      [11:0] data_in,
  output logic             busy_n,
  output logic             fifo_level_irq_n,
  // Test hooks
  input  wire logic        force_oor,
  output logic      [7:0]  ctl_writes
);
  logic [11:0] mem [8];
  logic [1:0]  rng [8];
  logic [11:0] bus_q, seq, held, do_q;
  logic [6:0]  conv;
  logic [3:0]  cnt, wc;
  logic        irq_en, fault, st_q, ck_q, rd_q, wr_q, cs_q, a_q;
  // Released bus shows the inverse
  assign data_in = !data_oe_n ? data_out : bus_q;
  // Device state and pin edges
  always @(posedge clock) begin
    fault = 1'b0;
    for (int i = 0; i < 8; i++) if (i < cnt && rng[i] != 2'b00) fault = 1'b1;
    if (sys_rst) begin
      cnt = 4'h0;
      irq_en = 1'b0;
      conv = 7'h00;
      seq = 12'h000;
      busy_n <= 1'b1;
      ctl_writes <= 8'h00;
      bus_q <= 12'h000;
    end else begin
      if (convert_start_n && !st_q) begin
        held = force_oor ? 12'h7ff : 12'h7fd + seq;
        conv = 7'd56;
        busy_n <= 1'b0;
      end else if (adc_clk && !ck_q && conv != 7'h00) begin
        busy_n <= 1'b1;
        conv = conv - 7'h01;
        if (conv == 7'h00 && cnt < 4'h8) begin
          mem[cnt] = held;
          rng[cnt] = {force_oor, 1'b0};
          cnt = cnt + 4'h1;
          seq = seq + 12'h001;
        end
      end
      if (!read_strobe_n && rd_q && !cs_n) bus_q <= addr0 ? {6'h00, fault, 1'b0, cnt} : mem[0];
      if (read_strobe_n && !rd_q && !cs_q) begin
        bus_q <= ~bus_q;
        if (!a_q && cnt != 4'h0) begin
          for (int i = 0; i < 7; i++) begin
            mem[i] = mem[i+1];
            rng[i] = rng[i+1];
          end
          cnt = cnt - 4'h1;
        end
      end
      if (write_strobe_n && !wr_q && !cs_q && a_q) begin
        wc = {1'b0, do_q[2:0]} + 4'h1;
        irq_en = do_q[3];
        cnt = 4'h0;
        seq = 12'h000;
        ctl_writes <= ctl_writes + 8'h01;
      end
    end
    fifo_level_irq_n <= !(irq_en && cnt >= wc);
    {st_q, ck_q, rd_q, wr_q, cs_q, a_q} <= {convert_start_n, adc_clk, read_strobe_n, write_strobe_n, cs_n, addr0};
    do_q <= data_out;
  end
endmodule
`default_nettype wire

// [testbench.sv]
// Purpose: Self-checking bench.
// Assumes: Device model on the converter pins.
// Notes:   Samples run 7fd+k from each control write.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
module testbench;
  import adcf_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [1:0] r;} adcf_row_s;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, force_oor = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        adc_clk, convert_start_n, cs_n, read_strobe_n, write_strobe_n, addr0, data_oe_n;
  logic        busy_n, fifo_level_irq_n;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [11:0] data_in, data_out, smp;
  logic [7:0]  ctl_writes;
  int          fail_count = 0;
  int          checks = 0;
  adcf_row_s rows [4] = '{'{REG_CTRL, 32'h80, '1, RESP_OKAY},
    '{REG_CFG, 32'h0, '1, RESP_OKAY}, '{REG_PERIOD, 32'h190, '1, RESP_OKAY},
    '{8'h10, 32'h0, 32'h0, RESP_SLVERR}};
  adcf_host i_dut (.*);
  adcf_dev_model i_dev (.*);
  always #12.5 clock = ~clock;
  //////////////////////////////////////////////////////////////////////////////
  // Each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    {rd_v, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // Poll a status bit, bounded
  task automatic wait_bit(input int b);
    rd(REG_STATUS);
    for (int i = 0; i < 150 && rd_v[b] !== 1'b1; i++) begin
      repeat (50) @(posedge clock);
      rd(REG_STATUS);
    end
  endtask
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (40000) @(posedge clock);
    fail_count++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (40) @(posedge clock);
    foreach (rows[i]) begin
      rd(rows[i].a);
      `CHK(rd_v & rows[i].m, rows[i].d)
      `CHK(resp, rows[i].r)
    end
    wr(8'h10, 32'h1);
    `CHK(resp, RESP_SLVERR)
    wr(REG_PERIOD, 32'h10); // Below the floor
    wr(REG_CFG, 32'h00f);
    wr(REG_CTRL, 32'h183);
    wait_bit(STAT_READY);
    `CHK(rd_v[STAT_READY], 1'b1)
    `CHK(rd_v[STAT_FAULT], 1'b0)
    for (int k = 0; k < 8; k++) begin
      rd(REG_SAMPLE + 8'(4 * k));
      smp = 12'h7fd + 12'(k);
      `CHK(rd_v, {{20{smp[11]}}, smp})
    end
    wr(REG_STATUS, 32'h8);
    rd(REG_STATUS);
    `CHK(rd_v[STAT_READY], 1'b0)
    wr(REG_CTRL, 32'h087);
    force_oor <= 1'b1;
    wait_bit(STAT_FAULT);
    `CHK(rd_v[STAT_FAULT], 1'b1)
    repeat (400) @(posedge clock);
    `CHK(ctl_writes, 8'h03)
    test_done();
  end
endmodule
`default_nettype wire
